// ===== logic/spi_port_pkg.sv
// Shared constants for the byte-wide SPI host/client port.
// Assumes one 40 MHz system clock and a small register port with 3-bit addresses.
`default_nettype none

package spi_port_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [2:0] ADDR_STATUS   = 3'h0;
    localparam logic [2:0] ADDR_CONTROL  = 3'h1;
    localparam logic [2:0] ADDR_FLAGS    = 3'h2;
    localparam logic [2:0] ADDR_BUFFER   = 3'h3;
    localparam logic [2:0] ADDR_RELOAD   = 3'h4;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int STAT_SMP_BIT   = 7;
    localparam int STAT_CKE_BIT   = 6;
    localparam int STAT_BF_BIT    = 0;
    localparam int CTRL_WRITE_COLLISION_FLAG_BIT  = 7;
    localparam int CTRL_EN_BIT    = 5;
    localparam int CTRL_CKP_BIT   = 4;
    localparam int FLAG_DONE_BIT  = 0;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] RST_STATUS  = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_BUFFER  = 8'h00;
    localparam logic [7:0] RST_RELOAD  = 8'h00;

    // ********************************************************************
    // Mode codes held in the low nibble of the control register
    // ********************************************************************
    localparam logic [3:0] MODE_HOST_DIV4   = 4'h0;
    localparam logic [3:0] MODE_HOST_DIV16  = 4'h1;
    localparam logic [3:0] MODE_HOST_DIV64  = 4'h2;
    localparam logic [3:0] MODE_HOST_TIMER  = 4'h3;
    localparam logic [3:0] MODE_CLIENT_SEL  = 4'h4;
    localparam logic [3:0] MODE_CLIENT_FREE = 4'h5;
    localparam logic [3:0] MODE_HOST_RELOAD = 4'hA;

    // ********************************************************************
    // Timing: SCK periods in system clocks and the derived half periods
    // ********************************************************************
    localparam int unsigned PERIOD_DIV4   = 4;
    localparam int unsigned PERIOD_DIV16  = 16;
    localparam int unsigned PERIOD_DIV64  = 64;
    localparam int unsigned HALF_DIV4     = PERIOD_DIV4 / 2;
    localparam int unsigned HALF_DIV16    = PERIOD_DIV16 / 2;
    localparam int unsigned HALF_DIV64    = PERIOD_DIV64 / 2;
    localparam int unsigned WORD_BITS     = 8;
    localparam int unsigned WORD_HALVES   = 2 * WORD_BITS;

    function automatic logic is_host(input logic [3:0] mode);
        return (mode == MODE_HOST_DIV4) || (mode == MODE_HOST_DIV16) ||
               (mode == MODE_HOST_DIV64) || (mode == MODE_HOST_TIMER) ||
               (mode == MODE_HOST_RELOAD);
    endfunction

    function automatic logic is_client(input logic [3:0] mode);
        return (mode == MODE_CLIENT_SEL) || (mode == MODE_CLIENT_FREE);
    endfunction

endpackage

`default_nettype wire

// ===== logic/rate_if.sv
// Link between the port core and its bit-rate generator.
// Assumes both ends sit on the same system clock.
`default_nettype none
`timescale 1ns/1ps

interface rate_if;
    logic [3:0] mode;
    logic [7:0] reload;
    logic       run;
    logic       tick;

    modport gen  (input mode, input reload, input run, output tick);
    modport user (output mode, output reload, output run, input tick);
endinterface

`default_nettype wire

// ===== logic/rate_gen.sv
// Bit-rate generator: one tick per SCK half period while a host word runs.
// Assumes timer_tick is a one-cycle pulse from logic on sys_clk.
`default_nettype none
`timescale 1ns/1ps

module rate_gen (
    // Clock and reset
    input  wire logic  sys_clk,
    input  wire logic  reset,
    // Timer source for the timer-driven rate
    input  wire logic  timer_tick,
    // Core side
    rate_if.gen        bus
);

    typedef struct packed {
        logic [9:0] cnt;
        logic       tick;
    } gen_state_t;

    gen_state_t st_ff;
    gen_state_t nxt_st;
    logic [9:0] half_len;

    always_comb begin
        case (bus.mode)
            spi_port_pkg::MODE_HOST_DIV16:  half_len = 10'(spi_port_pkg::HALF_DIV16);
            spi_port_pkg::MODE_HOST_DIV64:  half_len = 10'(spi_port_pkg::HALF_DIV64);
            spi_port_pkg::MODE_HOST_RELOAD: half_len = {1'b0, bus.reload, 1'b0} + 10'h002;
            default:                        half_len = 10'(spi_port_pkg::HALF_DIV4);
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!bus.run) begin
            nxt_st.cnt = 10'h000;
        end else if (bus.mode == spi_port_pkg::MODE_HOST_TIMER) begin
            // Each timer pulse is one SCK half, so SCK runs at half the timer rate.
            nxt_st.tick = timer_tick;
        end else if (st_ff.cnt >= half_len - 10'h001) begin
            nxt_st.cnt  = 10'h000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.tick = st_ff.tick;

endmodule

`default_nettype wire

// ===== logic/spi_host_client_port.sv
// Byte-wide full-duplex SPI port that runs as SCK host or as selected client.
// Assumes a register port on sys_clk; SCK, SDI and select arrive from pins and are synchronised.
//
// Chosen here: the address-and-strobe port and the address map.
`default_nettype none
`timescale 1ns/1ps

module spi_host_client_port (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Timer pulse for the timer-driven host rate
    input  wire logic       timer_tick,
    // Serial pins
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       sdi,
    output logic            sdo_out,
    output logic            sdo_oe,
    input  wire logic       sel_n
);

    typedef struct packed {
        logic       en;
        logic [3:0] mode;
        logic       ckp;
        logic       cke;
        logic       smp;
        logic       write_collision_flag;
        logic       bf;
        logic       done;
        logic [7:0] buffer;
        logic [7:0] reload;
        logic [7:0] shreg;
        logic [2:0] cnt;
        logic [4:0] half;
        logic       pend;
        logic [1:0] cap_dly;
        logic       busy;
        logic       sck;
        logic       sdo;
        logic       sdo_oe;
        logic       sck_oe;
        logic [7:0] rdata;
        logic       sck_s1;
        logic       sck_s2;
        logic       sck_d;
        logic       sel_s1;
        logic       sel_s2;
        logic       sdi_s1;
        logic       sdi_s2;
    } port_state_t;

    port_state_t st_ff;
    port_state_t nxt_st;

    // ********************************************************************
    // Bit-rate generator
    // ********************************************************************
    rate_if rif ();

    assign rif.mode   = st_ff.mode;
    assign rif.reload = st_ff.reload;
    assign rif.run    = st_ff.busy;

    rate_gen u_rate (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .timer_tick (timer_tick),
        .bus        (rif)
    );

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    logic       host;
    logic       client;
    logic       sel_ctl;
    logic       selected;
    logic       lead;
    logic       trail;
    logic       cap_edge;
    logic       out_edge;
    logic       shift_now;
    logic       word_done;
    logic       shifting;
    logic       buf_wr;
    logic [7:0] shifted;

    always_comb begin
        nxt_st    = st_ff;
        host      = st_ff.en && spi_port_pkg::is_host(st_ff.mode);
        client    = st_ff.en && spi_port_pkg::is_client(st_ff.mode);
        sel_ctl   = st_ff.mode == spi_port_pkg::MODE_CLIENT_SEL;
        selected  = !sel_ctl || !st_ff.sel_s2;
        lead      = 1'b0;
        trail     = 1'b0;
        shift_now = 1'b0;
        word_done = 1'b0;
        shifted   = {st_ff.shreg[6:0], st_ff.sdi_s2};
        shifting  = host ? st_ff.busy : (client && st_ff.cnt != 3'h0);
        buf_wr    = reg_wr && reg_addr == spi_port_pkg::ADDR_BUFFER;

        // Pin inputs pass two flops before anything looks at them.
        nxt_st.sck_s1 = sck_in;
        nxt_st.sck_s2 = st_ff.sck_s1;
        nxt_st.sck_d  = st_ff.sck_s2;
        nxt_st.sel_s1 = sel_n;
        nxt_st.sel_s2 = st_ff.sel_s1;
        nxt_st.sdi_s1 = sdi;
        nxt_st.sdi_s2 = st_ff.sdi_s1;

        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                spi_port_pkg::ADDR_STATUS: begin
                    // Only the upper two status bits take writes.
                    nxt_st.smp = reg_wdata[spi_port_pkg::STAT_SMP_BIT];
                    nxt_st.cke = reg_wdata[spi_port_pkg::STAT_CKE_BIT];
                end
                spi_port_pkg::ADDR_CONTROL: begin
                    nxt_st.write_collision_flag = st_ff.write_collision_flag && reg_wdata[spi_port_pkg::CTRL_WRITE_COLLISION_FLAG_BIT];
                    nxt_st.en   = reg_wdata[spi_port_pkg::CTRL_EN_BIT];
                    nxt_st.ckp  = reg_wdata[spi_port_pkg::CTRL_CKP_BIT];
                    nxt_st.mode = reg_wdata[3:0];
                end
                spi_port_pkg::ADDR_FLAGS: begin
                    nxt_st.done = st_ff.done && reg_wdata[spi_port_pkg::FLAG_DONE_BIT];
                end
                spi_port_pkg::ADDR_RELOAD: begin
                    nxt_st.reload = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // The shift register has no address of its own; the buffer is the only way in.
        if (buf_wr) begin
            if (shifting || st_ff.write_collision_flag) begin
                nxt_st.write_collision_flag = 1'b1;
            end else begin
                nxt_st.buffer = reg_wdata;
                nxt_st.shreg  = reg_wdata;
                nxt_st.sdo    = reg_wdata[7];
                if (host) begin
                    nxt_st.busy = 1'b1;
                    nxt_st.half = 5'h00;
                    nxt_st.cnt  = 3'h0;
                    nxt_st.pend = 1'b0;
                    nxt_st.cap_dly = 2'h0;
                end
            end
        end

        // Reading the buffer empties it; a completion in the same cycle wins below.
        if (reg_rd && reg_addr == spi_port_pkg::ADDR_BUFFER) begin
            nxt_st.bf = 1'b0;
        end

        // Find SCK edges: generated in host role, observed in client role.
        if (host && st_ff.busy && rif.tick && st_ff.half < 5'(spi_port_pkg::WORD_HALVES)) begin
            nxt_st.sck  = !st_ff.sck;
            nxt_st.half = st_ff.half + 5'h01;
            lead        = st_ff.sck == st_ff.ckp;
            trail       = !lead;
        end else if (client && selected && st_ff.sck_s2 != st_ff.sck_d) begin
            lead  = st_ff.sck_d == st_ff.ckp;
            trail = !lead;
        end

        cap_edge = st_ff.cke ? lead : trail;
        out_edge = st_ff.cke ? trail : lead;

        // SDI reaches the host two cycles late through its synchroniser, so a host capture
        // shifts two cycles after its SCK edge; otherwise the fastest rate would take the
        // previous bit. A late sample point holds the capture back by one half period instead.
        nxt_st.cap_dly = {st_ff.cap_dly[0], 1'b0};
        if (host && st_ff.pend && rif.tick) begin
            shift_now   = 1'b1;
            nxt_st.pend = 1'b0;
        end else if (cap_edge && host && st_ff.smp) begin
            nxt_st.pend = 1'b1;
        end else if (cap_edge && host) begin
            nxt_st.cap_dly[0] = 1'b1;
        end else if (cap_edge) begin
            shift_now = 1'b1;
        end
        if (host && st_ff.cap_dly[1]) begin
            shift_now = 1'b1;
        end

        if (shift_now) begin
            nxt_st.shreg = shifted;
            nxt_st.cnt   = st_ff.cnt + 3'h1;
            word_done    = st_ff.cnt == 3'(spi_port_pkg::WORD_BITS - 1);
        end
        if (out_edge) begin
            nxt_st.sdo = shift_now ? st_ff.shreg[6] : st_ff.shreg[7];
        end

        // A client's shift register is free again at once, a host's only when busy drops after edge sixteen; the word waits in the buffer.
        if (word_done) begin
            nxt_st.buffer = shifted;
            nxt_st.bf     = 1'b1;
            nxt_st.done   = 1'b1;
        end

        if (host) begin
            if (st_ff.busy && st_ff.half == 5'(spi_port_pkg::WORD_HALVES) && !st_ff.pend
                    && st_ff.cap_dly == 2'h0) begin
                nxt_st.busy = 1'b0;
            end
            if (!st_ff.busy && !buf_wr) begin
                nxt_st.sck = st_ff.ckp;
            end
        end

        // Deselect aborts the word wherever it stands.
        if (client && !selected) begin
            nxt_st.cnt  = 3'h0;
            nxt_st.pend = 1'b0;
        end

        if (!st_ff.en) begin
            nxt_st.busy = 1'b0;
            nxt_st.cnt  = 3'h0;
            nxt_st.half = 5'h00;
            nxt_st.pend = 1'b0;
            nxt_st.cap_dly = 2'h0;
            nxt_st.sck  = st_ff.ckp;
        end

        nxt_st.sck_oe = host;
        nxt_st.sdo_oe = host || (client && selected);

        // Read data stand for exactly one cycle after the strobe.
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                spi_port_pkg::ADDR_STATUS:
                    nxt_st.rdata = {st_ff.smp, st_ff.cke, 5'h00, st_ff.bf};
                spi_port_pkg::ADDR_CONTROL:
                    nxt_st.rdata = {st_ff.write_collision_flag, 1'b0, st_ff.en, st_ff.ckp, st_ff.mode};
                spi_port_pkg::ADDR_FLAGS:
                    nxt_st.rdata = {7'h00, st_ff.done};
                spi_port_pkg::ADDR_BUFFER:
                    nxt_st.rdata = st_ff.buffer;
                spi_port_pkg::ADDR_RELOAD:
                    nxt_st.rdata = st_ff.reload;
                default:
                    nxt_st.rdata = 8'h00;
            endcase
        end
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff        <= '0;
            st_ff.buffer <= spi_port_pkg::RST_BUFFER;
            st_ff.reload <= spi_port_pkg::RST_RELOAD;
            st_ff.sel_s1 <= 1'b1;
            st_ff.sel_s2 <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign sck_out   = st_ff.sck;
    assign sck_oe    = st_ff.sck_oe;
    assign sdo_out   = st_ff.sdo;
    assign sdo_oe    = st_ff.sdo_oe;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Edge count within one host word, read only by the checks.
    logic [4:0] edge_cnt_ff;
    always_ff @(posedge sys_clk) begin
        if (reset || (buf_wr && !shifting && !st_ff.write_collision_flag)) begin
            edge_cnt_ff <= 5'h00;
        end else if (host && st_ff.busy && st_ff.sck != nxt_st.sck) begin
            edge_cnt_ff <= edge_cnt_ff + 5'h01;
        end
    end

    sequence s_host_start;
        buf_wr && host && !shifting && !st_ff.write_collision_flag;
    endsequence

    sequence s_host_loaded;
        st_ff.busy && st_ff.half == 5'h00;
    endsequence

    a_write_starts: assert property (s_host_start |=> s_host_loaded)
        else $error("host write did not start a word");
    a_write_loads: assert property (s_host_start |=> st_ff.shreg == $past(reg_wdata) &&
        st_ff.buffer == $past(reg_wdata) && st_ff.sdo == $past(reg_wdata[7]))
        else $error("buffer write did not load shift register");
    a_sixteen_edges: assert property ($fell(st_ff.busy) && st_ff.en |-> edge_cnt_ff == 5'h10)
        else $error("host word did not give sixteen SCK edges");
    a_sck_idles: assert property (host && !st_ff.busy && !buf_wr |=> st_ff.sck == $past(st_ff.ckp))
        else $error("SCK not at idle level between words");
    a_done_flags: assert property (word_done |=> st_ff.bf && st_ff.done
        && st_ff.buffer == $past(shifted))
        else $error("completed word did not reach buffer and flags");
    a_done_sticky: assert property (st_ff.done && !(reg_wr && reg_addr == spi_port_pkg::ADDR_FLAGS)
        |=> st_ff.done)
        else $error("done flag dropped without software");
    a_read_clears: assert property (reg_rd && reg_addr == spi_port_pkg::ADDR_BUFFER && !word_done
        |=> !st_ff.bf)
        else $error("buffer read left full flag set");
    a_collision_drop: assert property (buf_wr && (shifting || st_ff.write_collision_flag) && !word_done
        |=> st_ff.write_collision_flag && $stable(st_ff.buffer))
        else $error("colliding write was not discarded");
    a_deselect_release: assert property (client && sel_ctl && st_ff.sel_s2
        |=> !st_ff.sdo_oe && st_ff.cnt == 3'h0)
        else $error("deselect did not release SDO");
    a_disable_idle: assert property (!st_ff.en |=> !st_ff.busy && !st_ff.sck_oe && !st_ff.sdo_oe)
        else $error("disabled port still active");

endmodule

`default_nettype wire

// ===== tb/spi_client_model.sv
// SPI client standing on the far side of the port while it runs as host.
// Assumes SCK idles low, capture on rising SCK and shift on falling SCK.
`timescale 1ns/1ps
`default_nettype none

module spi_client_model (
    // Serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    // Bench side
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte,
    output logic      [7:0] edges
);
    logic cap;

    initial rx_byte = 8'h00;
    initial edges = 8'h00;
    // Deselected, the line shows the inverse bit so stale data never passes for valid.
    assign miso = sel_n ? ~rx_byte[7] : rx_byte[7];
    always @(negedge sel_n) begin
        rx_byte = tx_byte;
        edges = 8'h00;
    end
    always @(posedge sck) begin
        if (!sel_n) begin
            cap <= mosi;
            edges <= edges + 8'h01;
        end
    end
    always @(negedge sck) begin
        if (!sel_n) rx_byte <= {rx_byte[6:0], cap};
    end
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the SPI host/client port.
// Assumes a 40 MHz sys_clk; the bench plays the host when the port is a client.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       timer_tick = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic       sck_in = 1'b0;
    logic       tb_mosi = 1'b0;
    logic       sel_n = 1'b1;
    logic       psel_n = 1'b1;
    logic       use_model = 1'b1;
    logic [7:0] part_tx = 8'h00;
    logic [7:0] part_rx;
    logic [7:0] part_edges;
    logic       sck_out;
    logic       sck_oe;
    logic       sdo_out;
    logic       sdo_oe;
    logic       part_miso;
    logic       sdi_w;
    logic       sck_w;
    int         mismatches = 0;
    int         compares = 0;

    // ****************************************************************
    // Clocks, pins and instances
    // ****************************************************************
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
        timer_tick <= (tick_cnt == 2'h2);
    end
    // The SCK wire has a pull-down, so an undriven line reads idle low.
    assign sck_w = sck_oe ? sck_out : 1'b0;
    assign sdi_w = use_model ? part_miso : tb_mosi;

    spi_host_client_port u_spi_host_client_port (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_tick(timer_tick), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi_w),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sel_n(sel_n)
    );
    spi_client_model u_spi_client_model (
        .sck(sck_w), .mosi(sdo_out), .sel_n(psel_n), .miso(part_miso),
        .tx_byte(part_tx), .rx_byte(part_rx), .edges(part_edges)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(n, e, v);
    endtask
    task automatic waitn(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_regs;
        for (int i = 0; i < 8; i++) rchk("reset value", 3'(i), 8'h00);
        wr(spi_port_pkg::ADDR_STATUS, 8'hFF);
        rchk("status access", spi_port_pkg::ADDR_STATUS, 8'hC0);
    endtask
    task automatic t_host(input logic [3:0] mode, input logic [7:0] tx, input logic [7:0] rtx);
        logic [7:0] v;
        use_model <= 1'b1;
        wr(spi_port_pkg::ADDR_CONTROL, 8'h00);
        wr(spi_port_pkg::ADDR_STATUS, 8'h40);
        wr(spi_port_pkg::ADDR_RELOAD, 8'h01);
        wr(spi_port_pkg::ADDR_CONTROL, {4'h2, mode});
        part_tx = rtx;
        psel_n <= 1'b0;
        wr(spi_port_pkg::ADDR_BUFFER, tx);
        v = 8'h00;
        for (int n = 0; n < 400 && v[0] !== 1'b1; n++) rd(spi_port_pkg::ADDR_FLAGS, v);
        waitn(100);
        chk("sck rising edges", 8'h08, part_edges);
        chk("word at client", tx, part_rx);
        rchk("status full", spi_port_pkg::ADDR_STATUS, 8'h41);
        rchk("received word", spi_port_pkg::ADDR_BUFFER, rtx);
        rchk("status after read", spi_port_pkg::ADDR_STATUS, 8'h40);
        rchk("done kept", spi_port_pkg::ADDR_FLAGS, 8'h01);
        wr(spi_port_pkg::ADDR_FLAGS, 8'h00);
        rchk("done cleared", spi_port_pkg::ADDR_FLAGS, 8'h00);
        psel_n <= 1'b1;
    endtask
    task automatic t_collide;
        wr(spi_port_pkg::ADDR_CONTROL, 8'h20);
        part_tx = 8'h5A;
        psel_n <= 1'b0;
        wr(spi_port_pkg::ADDR_BUFFER, 8'h11);
        wr(spi_port_pkg::ADDR_BUFFER, 8'h22);
        rchk("collision set", spi_port_pkg::ADDR_CONTROL, 8'hA0);
        waitn(100);
        chk("first word kept", 8'h11, part_rx);
        wr(spi_port_pkg::ADDR_FLAGS, 8'h00);
        wr(spi_port_pkg::ADDR_BUFFER, 8'h33);
        waitn(100);
        rchk("blocked write", spi_port_pkg::ADDR_FLAGS, 8'h00);
        wr(spi_port_pkg::ADDR_CONTROL, 8'h20);
        rchk("collision cleared", spi_port_pkg::ADDR_CONTROL, 8'h20);
        psel_n <= 1'b1;
        @(posedge sys_clk);
        part_tx = 8'hC3;
        psel_n <= 1'b0;
        wr(spi_port_pkg::ADDR_BUFFER, 8'h44);
        waitn(100);
        chk("second word sent", 8'h44, part_rx);
        rchk("second word held", spi_port_pkg::ADDR_BUFFER, 8'hC3);
        psel_n <= 1'b1;
    endtask
    // The bench is the host here: SCK runs at 200 ns and only inside frames.
    task automatic spi_word(input logic [7:0] tx, input int bits, output logic [7:0] rx);
        sel_n <= 1'b0;
        waitn(8);
        for (int i = 7; i > 7 - bits; i--) begin
            tb_mosi <= tx[i];
            waitn(4);
            sck_in <= 1'b1;
            waitn(2);
            rx[i] = sdo_out;
            waitn(2);
            sck_in <= 1'b0;
        end
        waitn(8);
        sel_n <= 1'b1;
        tb_mosi <= ~tb_mosi;
        waitn(8);
    endtask
    task automatic t_client;
        logic [7:0] rx;
        use_model <= 1'b0;
        wr(spi_port_pkg::ADDR_FLAGS, 8'h00);
        wr(spi_port_pkg::ADDR_CONTROL, 8'h00);
        wr(spi_port_pkg::ADDR_CONTROL, 8'h24);
        wr(spi_port_pkg::ADDR_BUFFER, 8'h96);
        chk("pins released", 8'h00, {6'h0, sck_oe, sdo_oe});
        spi_word(8'hFF, 3, rx);
        chk("sdo after deselect", 8'h00, {7'h0, sdo_oe});
        rchk("no word yet", spi_port_pkg::ADDR_FLAGS, 8'h00);
        wr(spi_port_pkg::ADDR_BUFFER, 8'h96);
        spi_word(8'h6B, 8, rx);
        chk("word from client", 8'h96, rx);
        rchk("word at client", spi_port_pkg::ADDR_BUFFER, 8'h6B);
        rchk("client done", spi_port_pkg::ADDR_FLAGS, 8'h01);
        // Without select control the client drives SDO and shifts regardless of the line.
        wr(spi_port_pkg::ADDR_CONTROL, 8'h00);
        wr(spi_port_pkg::ADDR_CONTROL, 8'h25);
        wr(spi_port_pkg::ADDR_BUFFER, 8'h5A);
        chk("free client drives", 8'h01, {7'h0, sdo_oe});
        spi_word(8'hC3, 8, rx);
        chk("word from free client", 8'h5A, rx);
        rchk("word at free client", spi_port_pkg::ADDR_BUFFER, 8'hC3);
    endtask

    initial begin
        waitn(3);
        reset <= 1'b0;
        t_reset_regs();
        t_host(spi_port_pkg::MODE_HOST_DIV4, 8'hA5, 8'h3C);
        t_host(spi_port_pkg::MODE_HOST_DIV16, 8'h81, 8'h7E);
        t_host(spi_port_pkg::MODE_HOST_DIV64, 8'h0F, 8'hF0);
        t_host(spi_port_pkg::MODE_HOST_TIMER, 8'h5C, 8'hA3);
        t_host(spi_port_pkg::MODE_HOST_RELOAD, 8'hE1, 8'h1E);
        t_collide();
        t_client();
        wrap_up();
    end
    initial begin
        waitn(40000);
        mismatches++;
        wrap_up();
    end
endmodule

`default_nettype wire
